// File: logic/ees_pkg.sv
// Purpose: Constants for the Ethernet error statistics counter bank
// Assumes: 32-bit AXI4-Lite register access, one word per counter
// Notes: Offsets are byte addresses
package ees_pkg;
    localparam int ees_counter_count = 9;
    localparam int ees_addr_width = 6;
    // Register byte offsets
    localparam logic [5:0] ees_alignment_errors_off = 6'h00;
    localparam logic [5:0] ees_deferred_tx_frames_off = 6'h04;
    localparam logic [5:0] ees_late_collisions_off = 6'h08;
    localparam logic [5:0] ees_excess_collision_frames_off = 6'h0c;
    localparam logic [5:0] ees_tx_underrun_frames_off = 6'h10;
    localparam logic [5:0] ees_carrier_sense_errors_off = 6'h14;
    localparam logic [5:0] ees_rx_resource_errors_off = 6'h18;
    localparam logic [5:0] ees_rx_overrun_frames_off = 6'h1c;
    localparam logic [5:0] ees_rx_symbol_errors_off = 6'h20;
    localparam logic [5:0] ees_control_off = 6'h24;
    // Counter indices (offset divided by four)
    localparam int ees_idx_align = 0;
    localparam int ees_idx_defer = 1;
    localparam int ees_idx_late = 2;
    localparam int ees_idx_excess = 3;
    localparam int ees_idx_under = 4;
    localparam int ees_idx_cse = 5;
    localparam int ees_idx_res = 6;
    localparam int ees_idx_ovr = 7;
    localparam int ees_idx_sym = 8;
    // Control register fields and network configuration bits
    localparam int ees_ctl_rx_enable_bit = 3;
    localparam int ees_ctl_write_enable_bit = 7;
    localparam int ees_cfg_big_frame_bit = 8;
    localparam int ees_cfg_full_duplex_bit = 1;
    localparam logic [31:0] ees_control_reset = 32'h0000_0000;
    // Frame length limits in bytes
    localparam logic [10:0] ees_min_frame = 11'h040;
    localparam logic [10:0] ees_max_frame = 11'h5ee;
    localparam logic [10:0] ees_max_big_frame = 11'h600;
    // Counter widths
    localparam int ees_narrow_width = 8;
    localparam int ees_wide_width = 16;
    localparam logic [1:0] ees_resp_okay = 2'h0;
    localparam logic [1:0] ees_resp_slverr = 2'h2;
endpackage : ees_pkg

// File: logic/ees_stats.sv
// Purpose: Error statistics counters of a 10/100 Ethernet MAC
// Assumes: Event strobes from the frame engines are one-cycle pulses, one per frame
// Notes: Counters clear on read and saturate at all ones
// Notes: A software write on a counting edge keeps the written value
`timescale 1ns/1ps
`default_nettype none
module ees_stats
    import ees_pkg::*;
#(
    parameter int narrow_width = ees_narrow_width,
    parameter int wide_width = ees_wide_width
) (
    input wire logic aclk,
    input wire logic aresetn,

    // AXI4-Lite slave
    input wire logic [ees_addr_width-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ees_addr_width-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,

    // Network configuration from the MAC
    input wire logic [31:0] net_config,

    // Transmit frame end: one pulse per frame with its outcome
    input wire logic tx_frame_done,
    input wire logic tx_deferred,
    input wire logic tx_collided,
    input wire logic tx_late_collision,
    input wire logic tx_excess_collisions,
    input wire logic tx_underrun,
    input wire logic tx_carrier_error,

    // Receive frame end: one pulse per frame with its outcome
    input wire logic rx_frame_done,
    input wire logic [10:0] rx_frame_bytes,
    input wire logic rx_odd_bits,
    input wire logic rx_crc_bad,
    input wire logic rx_symbol_seen,
    input wire logic rx_addr_match,
    input wire logic rx_no_buffer,
    input wire logic rx_dma_overrun,

    // Control bits for the MAC
    output logic rx_enable,
    output logic stats_write_enable
);

    // ----------------------------------------------------------------
    // Bus handshake state
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [ees_addr_width-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] control;
    logic [31:0] cnt [ees_counter_count];

    function automatic int unsigned reg_index(input logic [ees_addr_width-1:0] a);
        reg_index = 32'(a[ees_addr_width-1:2]);
    endfunction : reg_index

    function automatic logic is_counter(input logic [ees_addr_width-1:0] a);
        is_counter = (a[1:0] == 2'h0) && (reg_index(a) < ees_counter_count);
    endfunction : is_counter

    function automatic int counter_width(input int i);
        counter_width = (i == ees_idx_defer || i == ees_idx_res) ? wide_width : narrow_width;
    endfunction : counter_width

    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Unaligned or unmapped addresses answer with an error and no effect
    logic rd_is_counter;
    logic rd_is_control;
    logic wr_is_mapped;

    always_comb begin
        rd_is_counter = is_counter(s_axi_araddr);
        rd_is_control = (s_axi_araddr == ees_control_off);
        wr_is_mapped = is_counter(aw_addr) || (aw_addr == ees_control_off);
    end

    // ----------------------------------------------------------------
    // Write address and data capture, in either order
    // ----------------------------------------------------------------

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ees_resp_okay;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_is_mapped ? ees_resp_okay : ees_resp_slverr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= ees_resp_okay;
        end else if (do_read) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ees_resp_okay;
            if (rd_is_counter) begin
                s_axi_rdata <= cnt[reg_index(s_axi_araddr)];
            end else if (rd_is_control) begin
                s_axi_rdata <= control;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= ees_resp_slverr;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= ees_control_reset;
        end else if (do_write && aw_addr == ees_control_off) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb[b]) begin
                    control[b*8 +: 8] <= w_data[b*8 +: 8];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Control bits to the MAC, one cycle behind the register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_enable <= 1'b0;
            stats_write_enable <= 1'b0;
        end else begin
            rx_enable <= control[ees_ctl_rx_enable_bit];
            stats_write_enable <= control[ees_ctl_write_enable_bit];
        end
    end

    // ----------------------------------------------------------------
    // Frame classification
    // ----------------------------------------------------------------
    logic [10:0] max_len;
    logic rx_len_ok;
    logic rx_take;
    logic tx_take;
    logic tx_clean;
    logic half_duplex;
    logic ev_align;
    logic ev_resource;
    logic ev_overrun;
    logic ev_symbol;
    logic ev_defer;
    logic ev_late;
    logic ev_excess;
    logic ev_underrun;
    logic ev_carrier;
    logic [ees_counter_count-1:0] hit;

    // ----------------------------------------------------------------
    // Receive length window
    // ----------------------------------------------------------------
    // Both limits inclusive; longer frames belong to the jabber and
    // oversize counts, which live outside this bank
    always_comb begin
        max_len = net_config[ees_cfg_big_frame_bit] ? ees_max_big_frame : ees_max_frame;
        rx_len_ok = (rx_frame_bytes >= ees_min_frame) && (rx_frame_bytes <= max_len);
    end

    // ----------------------------------------------------------------
    // Receive outcomes
    // ----------------------------------------------------------------
    // Receive counts freeze while reception is off
    always_comb begin
        rx_take = rx_frame_done && control[ees_ctl_rx_enable_bit];
    end

    always_comb begin
        ev_align = 1'b0;
        ev_resource = 1'b0;
        ev_overrun = 1'b0;
        ev_symbol = 1'b0;
        if (rx_take) begin
            // Bad truncated CRC, or a symbol error, on an odd-bit frame
            ev_align = rx_len_ok && rx_odd_bits && (rx_crc_bad || rx_symbol_seen);
            ev_resource = rx_addr_match && rx_no_buffer;
            ev_overrun = rx_addr_match && rx_dma_overrun;
            ev_symbol = rx_symbol_seen;
        end
    end

    // ----------------------------------------------------------------
    // Transmit outcomes
    // ----------------------------------------------------------------
    always_comb begin
        tx_take = tx_frame_done;
        // An underrun frame is charged to the underrun count only
        tx_clean = tx_frame_done && !tx_underrun;
        half_duplex = !net_config[ees_cfg_full_duplex_bit];
    end

    always_comb begin
        ev_defer = 1'b0;
        ev_late = 1'b0;
        ev_excess = 1'b0;
        ev_underrun = 1'b0;
        ev_carrier = 1'b0;
        if (tx_take && tx_underrun) begin
            ev_underrun = 1'b1;
        end
        if (tx_clean) begin
            ev_defer = tx_deferred && !tx_collided;
            // Late collision also counted by the ordinary collision bank
            ev_late = tx_late_collision;
            ev_excess = tx_excess_collisions;
            // Counted on its own, other outcomes unchanged
            ev_carrier = tx_carrier_error && !tx_collided && half_duplex;
        end
    end

    // ----------------------------------------------------------------
    // Event vector, one bit per counter slot
    // ----------------------------------------------------------------
    always_comb begin
        hit = '0;
        hit[ees_idx_align] = ev_align;
        hit[ees_idx_defer] = ev_defer;
        hit[ees_idx_late] = ev_late;
        hit[ees_idx_excess] = ev_excess;
        hit[ees_idx_under] = ev_underrun;
        hit[ees_idx_cse] = ev_carrier;
        hit[ees_idx_res] = ev_resource;
        hit[ees_idx_ovr] = ev_overrun;
        hit[ees_idx_sym] = ev_symbol;
    end

    // ----------------------------------------------------------------
    // Counters: write, clear on read, saturating increment
    // ----------------------------------------------------------------
    // Priority per slot: software write, then read clear, then event.
    // A write on a counting edge drops that one event, the price of
    // letting software preset a count.
    for (genvar i = 0; i < ees_counter_count; i++) begin : g_cnt
        localparam int cw = counter_width(i);
        localparam logic [31:0] cmax = 32'((64'h1 << cw) - 64'h1);
        logic rd_hit;
        logic wr_hit;
        logic at_max;

        always_comb begin
            rd_hit = do_read && rd_is_counter && reg_index(s_axi_araddr) == i;
        end

        // Counter writes are ignored unless software unlocked them
        always_comb begin
            wr_hit = do_write && is_counter(aw_addr) && reg_index(aw_addr) == i
                && control[ees_ctl_write_enable_bit];
        end

        // Sticks at all ones rather than wrapping back to zero
        always_comb begin
            at_max = (cnt[i] == cmax);
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cnt[i] <= '0;
            end else if (wr_hit) begin
                cnt[i] <= w_data & cmax;
            end else if (rd_hit) begin
                // Increment racing the read survives as a count of one
                cnt[i] <= hit[i] ? 32'h0000_0001 : 32'h0000_0000;
            end else if (hit[i] && !at_max) begin
                cnt[i] <= cnt[i] + 32'h0000_0001;
            end
        end
    end

endmodule : ees_stats
`default_nettype wire

// File: tb/ees_checker.sv
// Purpose: Bus and control checks on the error statistics block
// Assumes: Only the top-level ports are visible here
// Notes: Counter contents are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module ees_checker
    import ees_pkg::*;
#(
    parameter int narrow_width = ees_narrow_width,
    parameter int wide_width = ees_wide_width
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ees_addr_width-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_enable,
    input wire logic stats_write_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    property p_rd_answer; s_rd_take |=> s_axi_rvalid && !s_axi_arready; endproperty
    property p_rd_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
    property p_rd_bad; s_rd_take ##0 (s_axi_araddr > ees_control_off)
        |=> s_axi_rresp == ees_resp_slverr && s_axi_rdata == 32'h0; endproperty
    // Narrow counters must never leak bits above their width
    property p_rd_narrow; s_rd_take ##0 (s_axi_araddr inside {6'h00, 6'h08, 6'h0c, 6'h10,
        6'h14, 6'h1c, 6'h20}) |=> s_axi_rdata[31:narrow_width] == '0; endproperty
    property p_rd_wide; s_rd_take ##0 (s_axi_araddr inside {6'h04, 6'h18})
        |=> s_axi_rdata[31:wide_width] == '0; endproperty
    property p_wr_answer; s_wr_take |=> !s_axi_awready ##1 s_axi_bvalid; endproperty
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready;
    endproperty
    property p_wen_cause; $changed(stats_write_enable) |-> $past(s_axi_bvalid)
        || $past(s_axi_bvalid, 2); endproperty
    property p_rxen_cause; $changed(rx_enable) |-> $past(s_axi_bvalid)
        || $past(s_axi_bvalid, 2); endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_rd_done: assert property (p_rd_done) else $error("read not closed");
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read accepted");
    a_rd_narrow: assert property (p_rd_narrow) else $error("narrow count too wide");
    a_rd_wide: assert property (p_rd_wide) else $error("wide count too wide");
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    a_b_done: assert property (p_b_done) else $error("write not closed");
    a_wen_cause: assert property (p_wen_cause) else $error("write enable moved alone");
    a_rxen_cause: assert property (p_rxen_cause) else $error("rx enable moved alone");
endmodule : ees_checker
`default_nettype wire

// File: tb/ees_mac_model.sv
// Purpose: Frame engine stand-in giving one outcome strobe per frame
// Assumes: Flags qualify the done pulse only
// Notes: Flags turn inverted after the pulse so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module ees_mac_model (
    input wire logic aclk,
    output logic tx_frame_done,
    output logic [5:0] tx_flags,
    output logic rx_frame_done,
    output logic [10:0] rx_frame_bytes,
    output logic [5:0] rx_flags
);
    initial begin
        {tx_frame_done, rx_frame_done, tx_flags, rx_flags, rx_frame_bytes} = '0;
    end
    // Flags: deferred, collided, late, excess, underrun, carrier
    task automatic tx(input logic [5:0] f);
        @(posedge aclk);
        tx_flags <= f;
        tx_frame_done <= 1'h1;
        @(posedge aclk);
        tx_frame_done <= 1'h0;
        tx_flags <= ~f;
    endtask : tx
    // Flags: odd bits, bad crc, symbol, match, no buffer, overrun
    task automatic rx(input logic [10:0] n, input logic [5:0] f);
        @(posedge aclk);
        rx_flags <= f;
        rx_frame_bytes <= n;
        rx_frame_done <= 1'h1;
        @(posedge aclk);
        rx_frame_done <= 1'h0;
        rx_flags <= ~f;
        rx_frame_bytes <= ~n;
    endtask : rx
endmodule : ees_mac_model
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the error statistics counters
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes: Frame outcomes come from the frame engine model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ees_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic bvalid, arready, rvalid, rx_en, wen, txd, rxd;
    logic [5:0] awaddr, araddr, txf, rxf;
    logic [31:0] wdata, rdata, net_config;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb;
    logic [10:0] rxn;
    int n_fail = 0;
    int n_checks = 0;
    ees_mac_model mdl (.aclk(aclk), .tx_frame_done(txd), .tx_flags(txf), .rx_frame_done(rxd),
        .rx_frame_bytes(rxn), .rx_flags(rxf));
    ees_stats uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .net_config(net_config), .tx_frame_done(txd), .tx_deferred(txf[5]),
        .tx_collided(txf[4]), .tx_late_collision(txf[3]), .tx_excess_collisions(txf[2]),
        .tx_underrun(txf[1]), .tx_carrier_error(txf[0]), .rx_frame_done(rxd),
        .rx_frame_bytes(rxn), .rx_odd_bits(rxf[5]), .rx_crc_bad(rxf[4]), .rx_symbol_seen(rxf[3]),
        .rx_addr_match(rxf[2]), .rx_no_buffer(rxf[1]), .rx_dma_overrun(rxf[0]),
        .rx_enable(rx_en), .stats_write_enable(wen));
    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end
    task automatic summarize;
        if (n_fail == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
        input logic [1:0] er = 2'h0);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'h7;
        // Address and data may be taken on different edges
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'h0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'h0;
            end
        join
        do @(posedge aclk); while (!bvalid);
        bready <= 1'h0;
        chk(32'(bresp), 32'(er));
    endtask : wr
    task automatic rc(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'h0;
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
    endtask : rc
    task automatic t_reset;
        for (int i = 0; i < ees_counter_count; i++) rc(6'(i * 4), 32'h0);
        rc(6'h28, 32'h0, ees_resp_slverr);
    endtask : t_reset
    task automatic t_rx;
        wr(ees_control_off, 32'h88);
        mdl.rx(11'h040, 6'h30);
        mdl.rx(11'h03f, 6'h30);
        mdl.rx(11'h5ee, 6'h30);
        mdl.rx(11'h5ef, 6'h30);
        mdl.rx(11'h064, 6'h28);
        mdl.rx(11'h064, 6'h10);
        mdl.rx(11'h064, 6'h06);
        mdl.rx(11'h064, 6'h05);
        net_config <= 32'h100;
        mdl.rx(11'h600, 6'h30);
        mdl.rx(11'h601, 6'h30);
        wr(ees_control_off, 32'h80);
        mdl.rx(11'h064, 6'h3f);
        rc(ees_alignment_errors_off, 32'h4);
        rc(ees_alignment_errors_off, 32'h0);
        rc(ees_rx_symbol_errors_off, 32'h1);
        rc(ees_rx_resource_errors_off, 32'h1);
        rc(ees_rx_overrun_frames_off, 32'h1);
    endtask : t_rx
    task automatic t_tx;
        net_config <= 32'h0;
        mdl.tx(6'h20);
        mdl.tx(6'h30);
        mdl.tx(6'h22);
        mdl.tx(6'h18);
        mdl.tx(6'h14);
        mdl.tx(6'h21);
        mdl.tx(6'h11);
        mdl.tx(6'h03);
        net_config <= 32'h2;
        mdl.tx(6'h01);
        rc(ees_deferred_tx_frames_off, 32'h2);
        rc(ees_late_collisions_off, 32'h1);
        rc(ees_excess_collision_frames_off, 32'h1);
        rc(ees_tx_underrun_frames_off, 32'h2);
        rc(ees_carrier_sense_errors_off, 32'h1);
    endtask : t_tx
    task automatic t_write;
        wr(ees_control_off, 32'h08);
        wr(ees_alignment_errors_off, 32'h55);
        rc(ees_alignment_errors_off, 32'h0);
        chk(32'(rx_en), 32'h1);
        chk(32'(wen), 32'h0);
        wr(ees_control_off, 32'h88);
        wr(ees_alignment_errors_off, 32'hffff_ffff);
        chk(32'(wen), 32'h1);
        mdl.rx(11'h040, 6'h30);
        rc(ees_alignment_errors_off, 32'hff);
        wr(ees_deferred_tx_frames_off, 32'hffff_ffff);
        mdl.tx(6'h20);
        rc(ees_deferred_tx_frames_off, 32'hffff);
        // Only the low byte lane lands; upper lanes keep their zeros
        wr(ees_control_off, 32'hffff_ff88, 4'h1);
        rc(ees_control_off, 32'h88);
        wr(6'h28, 32'h1, 4'hf, ees_resp_slverr);
    endtask : t_write
    task automatic t_race;
        fork
            rc(ees_rx_symbol_errors_off, 32'h0);
            mdl.rx(11'h064, 6'h08);
        join
        rc(ees_rx_symbol_errors_off, 32'h1);
    endtask : t_race
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, net_config} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_rx;
        t_tx;
        t_write;
        t_race;
        summarize;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        summarize;
    end
endmodule : testbench
bind ees_stats ees_checker #(.narrow_width(narrow_width), .wide_width(wide_width)) chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_enable, .stats_write_enable);
`default_nettype wire
